// [logic/shp_port.sv]
// Serial host port in SPI slave and SPI master modes
`timescale 1ns/100ps
`include "shp_map.svh"

module shp_port (
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  input  wire shp_pkg::shp_cfg_t      cfg,
  input  wire logic                   tx_wr,
  input  wire logic [`SHP_DW-1:0]     tx_data,
  input  wire logic                   rx_rd,
  output logic      [`SHP_DW-1:0]     rx_data,
  output shp_pkg::shp_status_t        status,
  output logic                        bus_error_irq,
  input  wire shp_pkg::shp_pins_in_t  pins_in,
  output shp_pkg::shp_pins_out_t      pins_out
);
  import shp_pkg::*;

  // State of the port apart from the receive FIFO
  typedef struct packed {
    shp_pins_in_t       sync1;
    shp_pins_in_t       sync2;
    logic               sck_q;
    shp_mst_t           mst;
    logic [`SHP_DW-1:0] shift_register;
    logic [`SHP_DW-1:0] transmit_holding_register;
    logic               tx_full;
    logic               tde;
    logic               out_bit;
    logic [4:0]         bits;
    logic [5:0]         edges;
    logic [8:0]         div;
    logic               sck_lvl;
    logic               word_started;
    logic               tx_loaded;
    logic               host_request_line_asrt;
    logic               bus_err;
    logic               overrun;
  } shp_st_t;

  localparam shp_st_t ST_RST = '{
    sync1                     : '1,
    sync2                     : '1,
    sck_q                     : 1'b0,
    mst                       : SHP_IDLE,
    shift_register            : `SHP_RST_WORD,
    transmit_holding_register : `SHP_RST_WORD,
    tx_full                   : 1'b0,
    tde                       : 1'b1,
    out_bit                   : 1'b0,
    bits                      : `SHP_RST_BITS,
    edges                     : `SHP_RST_EDGES,
    div                       : `SHP_RST_DIV,
    sck_lvl                   : 1'b0,
    word_started              : 1'b0,
    tx_loaded                 : 1'b0,
    host_request_line_asrt                 : 1'b0,
    bus_err                   : 1'b0,
    overrun                   : 1'b0
  };

  // Bits in one word for a word length code
  function automatic logic [4:0] shp_word_bits(input logic [1:0] wl);
    case (wl)
      `SHP_WL_8:  shp_word_bits = `SHP_BITS_8;
      `SHP_WL_16: shp_word_bits = `SHP_BITS_16;
      default:    shp_word_bits = `SHP_BITS_24;
    endcase
  endfunction : shp_word_bits

  // Moves a received word to the top of the data word
  function automatic logic [`SHP_DW-1:0] shp_align(
    input logic [`SHP_DW-1:0] v,
    input logic [1:0]         wl
  );
    case (wl)
      `SHP_WL_8:  shp_align = {v[7:0], 16'h0000};
      `SHP_WL_16: shp_align = {v[15:0], 8'h00};
      default:    shp_align = v;
    endcase
  endfunction : shp_align

  // Operating mode from the enable and select bits
  function automatic shp_mode_t shp_mode(input shp_cfg_t c);
    if (!c.port_enable_bit || c.i2c_select_bit)
      shp_mode = SHP_OFF;
    else if (c.master_select_bit)
      shp_mode = SHP_MASTER;
    else
      shp_mode = SHP_SLAVE;
  endfunction : shp_mode

  shp_st_t            st;
  shp_st_t            next_st;
  shp_mode_t          mode;
  logic               ss_act;
  logic               host_request_line_in;
  logic [4:0]         nbits;
  logic [8:0]         half_m1;
  logic               edge_ev;
  logic               lead;
  logic               samp;
  logic               din;
  logic [`SHP_DW-1:0] shifted;
  logic               push;
  logic [`SHP_DW-1:0] push_data;
  logic               fifo_empty;
  logic               fifo_full;
  logic               rx_cond;
  logic               tx_cond;
  logic               req;

  // Receive FIFO, emptied while the port is held in reset
  shp_rx_fifo u_rx_fifo (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .clear     (mode == SHP_OFF),
    .push      (push),
    .push_data (push_data),
    .pop       (rx_rd),
    .pop_data  (rx_data),
    .empty     (fifo_empty),
    .full      (fifo_full)
  );

  // Decoded mode and synchronised pin levels
  assign mode    = shp_mode(cfg);
  assign ss_act  = !st.sync2.ss_b;
  assign host_request_line_in = !st.sync2.host_request_b;
  assign nbits   = shp_word_bits(cfg.word_length_field);
  assign half_m1 = {1'b0, cfg.clk_div} + `SHP_MIN_HALF - 9'h001;

  // Next state of the port
  always_comb
  begin
    next_st   = st;
    edge_ev   = 1'b0;
    lead      = 1'b0;
    samp      = 1'b0;
    din       = 1'b0;
    shifted   = `SHP_RST_WORD;
    push      = 1'b0;
    push_data = `SHP_RST_WORD;
    rx_cond   = 1'b0;
    tx_cond   = 1'b0;
    req       = 1'b0;

    // Two flip-flop synchronisers and clock history
    next_st.sync1 = pins_in;
    next_st.sync2 = st.sync1;
    next_st.sck_q = st.sync2.sck;

    // Overrun clears on a FIFO read; a new overrun below wins
    if (rx_rd)
      next_st.overrun = 1'b0;

    case (mode)
      SHP_SLAVE:
      begin
        // External clock edges count only while selected
        din     = st.sync2.mosi;
        edge_ev = ss_act && (st.sck_q != st.sync2.sck);
        lead    = (st.sck_q == cfg.cpol);
        samp    = cfg.cpha ? !lead : lead;
        if (!ss_act)
        begin
          next_st.bits         = `SHP_RST_BITS;
          next_st.word_started = 1'b0;
        end
        else if (!edge_ev && st.bits == `SHP_RST_BITS
                 && !st.word_started && st.tx_full)
        begin
          // Holding word moves in only between words
          next_st.shift_register = st.transmit_holding_register;
          next_st.out_bit        = st.transmit_holding_register[`SHP_DW-1];
          next_st.tx_full        = 1'b0;
          next_st.tde            = 1'b1;
          next_st.tx_loaded      = 1'b1;
        end
        if (!ss_act && st.tx_full && !st.word_started)
        begin
          // Preload while deselected so phase 0 has its first bit ready
          next_st.shift_register = st.transmit_holding_register;
          next_st.out_bit        = st.transmit_holding_register[`SHP_DW-1];
          next_st.tx_full        = 1'b0;
          next_st.tde            = 1'b1;
          next_st.tx_loaded      = 1'b1;
        end
      end

      SHP_MASTER:
      begin
        din = st.sync2.miso;
        if (ss_act)
          next_st.bus_err = 1'b1;
        case (st.mst)
          SHP_IDLE:
          begin
            next_st.sck_lvl = cfg.cpol;
            // Start needs a written word, no bus error, and a request unless the request enable field is off
            if (st.tx_full && !st.bus_err
                && (cfg.request_enable_field == `SHP_REQ_OFF
                    || host_request_line_in))
            begin
              next_st.shift_register = st.transmit_holding_register;
              next_st.out_bit = st.transmit_holding_register[`SHP_DW-1];
              next_st.tx_full = 1'b0;
              next_st.tde     = cfg.cpha;
              next_st.mst     = SHP_RUN;
              next_st.div     = `SHP_RST_DIV;
              next_st.edges   = `SHP_RST_EDGES;
              next_st.bits    = `SHP_RST_BITS;
            end
          end
          SHP_RUN:
          begin
            // Divider toggles the clock once every half period
            if (st.div == half_m1)
            begin
              next_st.div     = `SHP_RST_DIV;
              edge_ev         = 1'b1;
              lead            = (st.sck_lvl == cfg.cpol);
              samp            = cfg.cpha ? !lead : lead;
              next_st.sck_lvl = !st.sck_lvl;
              next_st.edges   = st.edges + 6'h01;
              if (st.edges + 6'h01 == {nbits, 1'b0})
              begin
                // Whole word clocked; wait for the next start
                next_st.mst = SHP_IDLE;
                if (!cfg.cpha)
                  next_st.tde = !st.tx_full;
              end
            end
            else
              next_st.div = st.div + 9'h001;
          end
          default:
            next_st.mst = SHP_IDLE;
        endcase
      end

      default:
        next_st.mst = SHP_IDLE;
    endcase

    // Shared shifter: sample on one edge, drive on the other
    if (edge_ev)
    begin
      if (lead)
      begin
        next_st.word_started = 1'b1;
        next_st.tx_loaded    = 1'b0;
      end
      if (samp)
      begin
        shifted = {st.shift_register[`SHP_DW-2:0], din};
        next_st.shift_register = shifted;
        next_st.bits = st.bits + 5'h01;
        if (st.bits + 5'h01 == nbits)
        begin
          // Keep the received word MSB-aligned so a resend starts at its top
          next_st.shift_register = shp_align(shifted, cfg.word_length_field);
          next_st.bits         = `SHP_RST_BITS;
          next_st.word_started = 1'b0;
          if (fifo_full)
            next_st.overrun = 1'b1;
          else
          begin
            push      = 1'b1;
            push_data = shp_align(shifted, cfg.word_length_field);
          end
        end
      end
      else
        next_st.out_bit = st.shift_register[`SHP_DW-1];
    end

    // Slave request line conditions
    rx_cond = !st.word_started && !fifo_full;
    tx_cond = st.tx_loaded;
    case (cfg.request_enable_field)
      `SHP_REQ_RX:   req = rx_cond;
      `SHP_REQ_TX:   req = tx_cond;
      `SHP_REQ_BOTH: req = rx_cond && tx_cond;
      default:       req = 1'b0;
    endcase
    next_st.host_request_line_asrt = (mode == SHP_SLAVE) && req;

    // A software write fills the holding register after any load above
    if (tx_wr)
    begin
      next_st.transmit_holding_register = tx_data;
      next_st.tx_full = 1'b1;
      next_st.tde     = 1'b0;
    end

    // Clearing the enable holds the port in its reset state
    if (mode == SHP_OFF)
    begin
      next_st       = ST_RST;
      next_st.sync1 = pins_in;
      next_st.sync2 = st.sync1;
      next_st.sck_q = st.sync2.sck;
      next_st.sck_lvl = cfg.cpol;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= ST_RST;
    else
      st <= next_st;
  end

  // Pin drivers per mode
  always_comb
  begin
    pins_out.sck               = st.sck_lvl;
    pins_out.sck_oe_b          = (mode != SHP_MASTER);
    pins_out.mosi              = st.out_bit;
    pins_out.mosi_oe_b         = (mode != SHP_MASTER);
    pins_out.miso              = st.out_bit;
    pins_out.miso_oe_b         = !((mode == SHP_SLAVE) && ss_act);
    pins_out.host_request_b    = !st.host_request_line_asrt;
    pins_out.host_request_oe_b = (mode != SHP_SLAVE);
  end

  // Status flags
  always_comb
  begin
    status.transmit_empty_flag    = st.tde;
    status.receive_not_empty_flag = !fifo_empty;
    status.receive_full_flag      = fifo_full;
    status.overrun_flag           = st.overrun;
    status.bus_error_flag         = st.bus_err;
    if (mode == SHP_MASTER)
      status.port_busy_flag = st.tx_full || (st.mst == SHP_RUN);
    else if (mode == SHP_SLAVE)
      status.port_busy_flag = ss_act;
    else
      status.port_busy_flag = 1'b0;
  end

  // Bus error interrupt request
  assign bus_error_irq = st.bus_err && cfg.bus_error_interrupt_enable;

endmodule : shp_port

// [logic/shp_map.svh]
// Constants of the serial host port: widths, codes, reset values, timing
`ifndef SHP_MAP_SVH
`define SHP_MAP_SVH

// Data path
`define SHP_DW            24
`define SHP_FIFO_DEPTH    4
`define SHP_PTR_W         2
`define SHP_CNT_W         3
`define SHP_FIFO_FULL_CNT 3'h4

// Word length field codes and bit counts
`define SHP_WL_8          2'h0
`define SHP_WL_16         2'h1
`define SHP_BITS_8        5'h08
`define SHP_BITS_16       5'h10
`define SHP_BITS_24       5'h18

// Request enable field codes
`define SHP_REQ_OFF       2'h0
`define SHP_REQ_RX        2'h1
`define SHP_REQ_TX        2'h2
`define SHP_REQ_BOTH      2'h3

// Master clock: half period is clk_div plus this many core cycles
`define SHP_MIN_HALF      9'h004

// Reset values
`define SHP_RST_WORD      24'h000000
`define SHP_RST_BITS      5'h00
`define SHP_RST_EDGES     6'h00
`define SHP_RST_DIV       9'h000

`endif

// [logic/shp_pkg.sv]
// Types shared by the serial host port modules
package shp_pkg;

  // Configuration bits driven by software
  typedef struct packed {
    logic       port_enable_bit;
    logic       i2c_select_bit;
    logic       master_select_bit;
    logic       cpol;
    logic       cpha;
    logic [7:0] clk_div;
    logic [1:0] word_length_field;
    logic [1:0] request_enable_field;
    logic       bus_error_interrupt_enable;
  } shp_cfg_t;

  // Status bits seen by software
  typedef struct packed {
    logic transmit_empty_flag;
    logic receive_not_empty_flag;
    logic receive_full_flag;
    logic overrun_flag;
    logic bus_error_flag;
    logic port_busy_flag;
  } shp_status_t;

  // Pin levels arriving from outside
  typedef struct packed {
    logic sck;
    logic miso;
    logic mosi;
    logic ss_b;
    logic host_request_b;
  } shp_pins_in_t;

  // Pin levels and enables driven out; enables are low while driving
  typedef struct packed {
    logic sck;
    logic sck_oe_b;
    logic miso;
    logic miso_oe_b;
    logic mosi;
    logic mosi_oe_b;
    logic host_request_b;
    logic host_request_oe_b;
  } shp_pins_out_t;

  // Operating mode of the port
  typedef enum logic [1:0] {
    SHP_OFF    = 2'b00,
    SHP_SLAVE  = 2'b01,
    SHP_MASTER = 2'b10
  } shp_mode_t;

  // Master word sequencer
  typedef enum logic [0:0] {
    SHP_IDLE = 1'b0,
    SHP_RUN  = 1'b1
  } shp_mst_t;

endpackage : shp_pkg

// [logic/shp_rx_fifo.sv]
// Receive FIFO of the serial host port
`timescale 1ns/100ps
`include "shp_map.svh"

module shp_rx_fifo (
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic                clear,
  input  wire logic                push,
  input  wire logic [`SHP_DW-1:0]  push_data,
  input  wire logic                pop,
  output logic      [`SHP_DW-1:0]  pop_data,
  output logic                     empty,
  output logic                     full
);
  import shp_pkg::*;

  typedef struct packed {
    logic [`SHP_FIFO_DEPTH-1:0][`SHP_DW-1:0] mem;
    logic [`SHP_PTR_W-1:0]                   wr;
    logic [`SHP_PTR_W-1:0]                   rd;
    logic [`SHP_CNT_W-1:0]                   cnt;
  } shp_fifo_st_t;

  shp_fifo_st_t st;
  shp_fifo_st_t next_st;
  logic         do_push;
  logic         do_pop;

  // Flags and head word
  assign empty    = (st.cnt == '0);
  assign full     = (st.cnt == `SHP_FIFO_FULL_CNT);
  assign pop_data = st.mem[st.rd];

  // Pointer and count update; a clear empties the FIFO
  always_comb
  begin
    next_st = st;
    do_push = push && !full;
    do_pop  = pop && !empty;
    if (do_push)
    begin
      next_st.mem[st.wr] = push_data;
      next_st.wr         = st.wr + 1'b1;
    end
    if (do_pop)
      next_st.rd = st.rd + 1'b1;
    if (do_push && !do_pop)
      next_st.cnt = st.cnt + 1'b1;
    else if (do_pop && !do_push)
      next_st.cnt = st.cnt - 1'b1;
    if (clear)
    begin
      next_st.wr  = '0;
      next_st.rd  = '0;
      next_st.cnt = '0;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end

endmodule : shp_rx_fifo

// [sim/shp_port_monitor.sv]
// Checker of the serial host port pins and flags, bound to the port
`timescale 1ns/100ps
`include "shp_map.svh"
module shp_port_monitor (
  input wire logic                   core_clk,
  input wire logic                   rst_b,
  input wire shp_pkg::shp_cfg_t      cfg,
  input wire logic                   tx_wr,
  input wire logic [`SHP_DW-1:0]     tx_data,
  input wire logic                   rx_rd,
  input wire logic [`SHP_DW-1:0]     rx_data,
  input wire shp_pkg::shp_status_t   status,
  input wire logic                   bus_error_irq,
  input wire shp_pkg::shp_pins_in_t  pins_in,
  input wire shp_pkg::shp_pins_out_t pins_out
);
  import shp_pkg::*;
  logic en;
  logic slv;
  logic mst;
  // Decoded operating mode
  assign en  = cfg.port_enable_bit & ~cfg.i2c_select_bit;
  assign slv = en & ~cfg.master_select_bit;
  assign mst = en & cfg.master_select_bit;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // Interrupt request is the error flag gated by its enable
  a_irq_level: assert property (
    $stable(cfg.bus_error_interrupt_enable) |-> bus_error_irq ==
    (status.bus_error_flag & cfg.bus_error_interrupt_enable))
    else $error("irq differs from error flag");
  // Pin directions per mode
  a_master_pins: assert property (
    mst [*3] |-> !pins_out.sck_oe_b && !pins_out.mosi_oe_b &&
    pins_out.miso_oe_b && pins_out.host_request_oe_b)
    else $error("master pin direction wrong");
  a_slave_pins: assert property (
    slv [*3] |-> pins_out.sck_oe_b && pins_out.mosi_oe_b &&
    !pins_out.host_request_oe_b)
    else $error("slave pin direction wrong");
  a_off_released: assert property (
    !en [*3] |-> pins_out.sck_oe_b && pins_out.mosi_oe_b &&
    pins_out.miso_oe_b && pins_out.host_request_oe_b)
    else $error("pin driven while port off");
  // Holding register write clears the empty flag
  a_write_fills: assert property (
    tx_wr && en |=> !en || !status.transmit_empty_flag)
    else $error("empty flag stayed after write");
  // Busy and error follow the select input
  a_slave_busy: assert property (
    (slv && $stable(pins_in.ss_b)) [*5] |->
    status.port_busy_flag == !pins_in.ss_b)
    else $error("slave busy not tracking select");
  a_select_error: assert property (
    (mst && !pins_in.ss_b) [*5] |-> status.bus_error_flag)
    else $error("select in master mode no error");
  // Receive request level against FIFO room
  a_rx_request: assert property (
    (slv && cfg.request_enable_field == `SHP_REQ_RX && pins_in.ss_b &&
    $stable(status.receive_full_flag)) [*6] |->
    pins_out.host_request_b == status.receive_full_flag)
    else $error("receive request level wrong");
  a_idle_clock: assert property (
    (mst && !status.port_busy_flag) [*2] |-> pins_out.sck == cfg.cpol)
    else $error("master clock moved while idle");
  // Main scenarios reached
  c_slave_word: cover property (slv && $rose(status.receive_not_empty_flag));
  c_master_word: cover property (mst && $fell(status.port_busy_flag));
  c_bus_error: cover property ($rose(status.bus_error_flag));
endmodule : shp_port_monitor

bind shp_port shp_port_monitor i_mon (
  .core_clk(core_clk), .rst_b(rst_b), .cfg(cfg), .tx_wr(tx_wr),
  .tx_data(tx_data), .rx_rd(rx_rd), .rx_data(rx_data), .status(status),
  .bus_error_irq(bus_error_irq), .pins_in(pins_in), .pins_out(pins_out));

// [sim/shp_spi_peer.sv]
// Model of the far SPI party: host master or a selected slave device
`timescale 1ns/100ps
module shp_spi_peer (
  input wire shp_pkg::shp_cfg_t      cfg,
  input wire shp_pkg::shp_pins_out_t dut_out,
  output shp_pkg::shp_pins_in_t      dut_in
);
  import shp_pkg::*;
  logic        m_sck  = 1'b0;
  logic        m_mosi = 1'b0;
  logic        ss_b   = 1'b1;
  logic        req_b  = 1'b1;
  logic        s_miso = 1'b0;
  logic [23:0] s_sh   = 24'h000000;
  logic [23:0] rcv    = 24'h000000;
  logic        sck_w;
  logic        miso_w;
  logic        mosi_w;
  logic        lead;
  // Wire levels from whichever party drives each pin
  assign sck_w  = dut_out.sck_oe_b ? m_sck : dut_out.sck;
  assign mosi_w = dut_out.mosi_oe_b ? m_mosi : dut_out.mosi;
  assign miso_w = dut_out.miso_oe_b ? s_miso : dut_out.miso;
  assign lead   = sck_w != cfg.cpol;
  assign dut_in = {sck_w, miso_w, mosi_w, ss_b,
    dut_out.host_request_oe_b ? req_b : dut_out.host_request_b};
  // Slave role: shift on the clock edges the port drives
  always @(sck_w)
    if (cfg.master_select_bit && !dut_out.sck_oe_b)
    begin
      if (lead)
        req_b = 1'b1;
      if (lead == cfg.cpha)
      begin
        if (cfg.cpha)
          s_miso = s_sh[23];
        s_sh = s_sh << 1;
        if (!cfg.cpha)
          s_miso = s_sh[23];
      end
      else
        rcv = {rcv[22:0], mosi_w};
    end
  // Load the word the slave role sends next
  task sld(input logic [23:0] w);
    s_sh = w;
    s_miso = w[23];
  endtask : sld
  // Master role: k bits of an n-bit word, clock still outside frames
  task xfer(input logic [23:0] w, input int k, input int n,
            output logic [23:0] r);
    r = 24'h000000;
    m_sck = cfg.cpol;
    ss_b = 1'b0;
    for (int i = 0; i < k; i++)
    begin
      if (!cfg.cpha)
        m_mosi = w[23-i];
      #62.5 m_sck = ~cfg.cpol;
      if (cfg.cpha)
        m_mosi = w[23-i];
      else
        r = {r[22:0], miso_w};
      #62.5 m_sck = cfg.cpol;
      if (cfg.cpha)
        r = {r[22:0], miso_w};
    end
    #62.5 ss_b = 1'b1;
    m_mosi = ~m_mosi;
    r = r << (24 - n);
  endtask : xfer
endmodule : shp_spi_peer

// [sim/shp_port_tb_top.sv]
// Self-checking bench of the serial host port in both SPI modes
`timescale 1ns/100ps
`include "shp_map.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  mismatches++; $display("CHECK FAILED at %0t got %h exp %h", \
  $time, (a), (b)); end end
module shp_port_tb_top;
  import shp_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst_b    = 1'b0;
  logic              tx_wr    = 1'b0;
  logic              rx_rd    = 1'b0;
  logic              irq;
  logic [`SHP_DW-1:0] tx_data = 24'h000000;
  logic [`SHP_DW-1:0] rx_data;
  logic [`SHP_DW-1:0] r;
  shp_cfg_t          cfg      = '0;
  shp_status_t       st;
  shp_pins_in_t      pin;
  shp_pins_out_t     pout;
  int                mismatches      = 0;
  int                samples_checked = 0;

  shp_port i_dut (.core_clk(core_clk), .rst_b(rst_b), .cfg(cfg),
    .tx_wr(tx_wr), .tx_data(tx_data), .rx_rd(rx_rd), .rx_data(rx_data),
    .status(st), .bus_error_irq(irq), .pins_in(pin), .pins_out(pout));
  shp_spi_peer i_peer (.cfg(cfg), .dut_out(pout), .dut_in(pin));

  // 100 MHz core clock
  always #5 core_clk = ~core_clk;

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  function automatic int nb(input logic [1:0] wl);
    return wl == `SHP_WL_8 ? 8 : wl == `SHP_WL_16 ? 16 : 24;
  endfunction : nb
  // Individual reset before every change of mode
  task mode(input logic m, input logic [1:0] pp, wl, rq);
    cfg.port_enable_bit = 1'b0;
    cyc(3);
    cfg = '{1'b1, 1'b0, m, pp[1], pp[0], 8'h02, wl, rq, 1'b1};
    cyc(4);
  endtask : mode
  task wr(input logic [23:0] d);
    tx_data = d;
    tx_wr = 1'b1;
    cyc(1);
    tx_wr = 1'b0;
  endtask : wr
  task pop;
    rx_rd = 1'b1;
    cyc(1);
    rx_rd = 1'b0;
  endtask : pop
  task widle;
    int k;
    k = 0;
    while (st.port_busy_flag !== 1'b0 && k < 900)
    begin
      cyc(1);
      k++;
    end
    `CHK(k < 900, 1'b1)
  endtask : widle

  // Slave: every clock mode and length, then resend of shift contents
  task t_slave;
    logic [23:0] m, w, k;
    for (int i = 0; i < 4; i++)
    begin
      k = 24'hFFFFFF << (24 - nb(i[1:0]));
      m = 24'hC35A96 >> i;
      w = 24'h9D2E4B ^ m;
      mode(1'b0, i[1:0], i[1:0], `SHP_REQ_OFF);
      wr(w);
      cyc(4);
      `CHK(st.transmit_empty_flag, 1'b1)
      i_peer.xfer(m, nb(i[1:0]), nb(i[1:0]), r);
      cyc(8);
      `CHK(r, w & k)
      `CHK(rx_data, m & k)
      pop;
      i_peer.xfer(~m, nb(i[1:0]), nb(i[1:0]), r);
      cyc(8);
      `CHK(r, m & k)
      `CHK(rx_data, ~m & k)
    end
    $display("slave test done");
  endtask : t_slave

  // Slave: select lost mid-word drops the partial word
  task t_abort;
    mode(1'b0, 2'h1, `SHP_WL_8, `SHP_REQ_OFF);
    i_peer.xfer(24'h5A0000, 5, 8, r);
    cyc(8);
    `CHK(st.receive_not_empty_flag, 1'b0)
    i_peer.xfer(24'hC30000, 8, 8, r);
    cyc(8);
    `CHK(rx_data, 24'hC30000)
    pop;
    `CHK(st.receive_not_empty_flag, 1'b0)
    $display("abort test done");
  endtask : t_abort

  // Slave request line in the receive, both and transmit enable settings
  task t_req;
    mode(1'b0, 2'h1, `SHP_WL_8, `SHP_REQ_RX);
    `CHK(pout.host_request_b, 1'b0)
    repeat (5) i_peer.xfer(24'h110000, 8, 8, r);
    cyc(8);
    `CHK(pout.host_request_b, 1'b1)
    `CHK(st.overrun_flag, 1'b1)
    cfg.request_enable_field = `SHP_REQ_BOTH;
    pop;
    `CHK(st.overrun_flag, 1'b0)
    cyc(3);
    `CHK(pout.host_request_b, 1'b1)
    wr(24'h770000);
    cyc(3);
    `CHK(pout.host_request_b, 1'b0)
    fork
      i_peer.xfer(24'h220000, 8, 8, r);
      begin
        #140;
        `CHK(pout.host_request_b, 1'b1)
      end
    join
    `CHK(r, 24'h770000)
    cfg.request_enable_field = `SHP_REQ_TX;
    wr(24'h440000);
    cyc(3);
    `CHK(pout.host_request_b, 1'b0)
    $display("request test done");
  endtask : t_req

  // Master: each clock mode and length, request input ignored
  task t_master;
    logic [23:0] w;
    int k;
    for (int i = 0; i < 4; i++)
    begin
      mode(1'b1, i[1:0], i[1:0], `SHP_REQ_OFF);
      w = 24'h9E3779 << i;
      i_peer.sld(~w);
      wr(w);
      k = 0;
      while (i_peer.sck_w === i[1] && k < 50)
      begin
        cyc(1);
        k++;
      end
      `CHK(st.transmit_empty_flag, i[0])
      widle;
      cyc(2);
      w = w & (24'hFFFFFF << (24 - nb(i[1:0])));
      `CHK(i_peer.rcv << (24 - nb(i[1:0])), w)
      `CHK(rx_data, ~w & (24'hFFFFFF << (24 - nb(i[1:0]))))
    end
    $display("master test done");
  endtask : t_master

  // Master paced by the far side request
  task t_hand;
    mode(1'b1, 2'h1, `SHP_WL_8, `SHP_REQ_TX);
    repeat (2)
    begin
      wr(24'h810000);
      cyc(40);
      `CHK(pout.sck, 1'b0)
      `CHK(st.port_busy_flag, 1'b1)
      i_peer.req_b = 1'b0;
      widle;
      `CHK(i_peer.rcv[7:0], 8'h81)
    end
    $display("handshake test done");
  endtask : t_hand

  // Master with select asserted: error, word ends, then suspended
  task t_berr;
    mode(1'b1, 2'h1, `SHP_WL_16, `SHP_REQ_OFF);
    wr(24'h123400);
    cyc(30);
    i_peer.ss_b = 1'b0;
    cyc(8);
    `CHK(st.bus_error_flag, 1'b1)
    `CHK(irq, 1'b1)
    widle;
    `CHK(st.receive_not_empty_flag, 1'b1)
    wr(24'h560000);
    cyc(60);
    `CHK(st.port_busy_flag, 1'b1)
    `CHK(st.transmit_empty_flag, 1'b0)
    i_peer.ss_b = 1'b1;
    cfg.i2c_select_bit = 1'b1;
    cyc(4);
    `CHK(st.bus_error_flag, 1'b0)
    `CHK(pout.sck_oe_b, 1'b1)
    $display("bus error test done");
  endtask : t_berr

  task results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  // Main sequence
  initial
  begin
    repeat (16) @(posedge core_clk);
    #1 rst_b = 1'b1;
    cyc(2);
    t_slave;
    t_abort;
    t_req;
    t_master;
    t_hand;
    t_berr;
    results;
  end
  // Watchdog well past the expected run
  initial
  begin
    #300000;
    mismatches++;
    results;
  end
endmodule : shp_port_tb_top
